// File: hw/timer_params.svh
// Purpose: Register offsets, field positions and fixed values of the timer.
// Assumes: Included by its bare name wherever a constant is needed.
// Notes:   Definitions only.
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// Register byte offsets on the register bus.
`define TMR_OFF_CTRL     4'h0
`define TMR_OFF_COUNT    4'h4
`define TMR_OFF_RELOAD   4'h8
`define TMR_OFF_CAPTURE  4'hc

// Control register field positions.
`define TMR_CTRL_EN      0
`define TMR_CTRL_MODE_LO 1
`define TMR_CTRL_MODE_HI 3
`define TMR_CTRL_PSC_LO  4
`define TMR_CTRL_PSC_HI  6
`define TMR_CTRL_POL     7
`define TMR_CTRL_OUTEN   8
`define TMR_CTRL_ISRC_LO 9
`define TMR_CTRL_ISRC_HI 10
`define TMR_CTRL_CAPF    11

// Reset and restart values.
`define TMR_RESTART      16'h0001
`define TMR_COUNT_RST    16'h0001
`define TMR_RELOAD_RST   16'hffff
`define TMR_CAPTURE_RST  16'h0000
`define TMR_PSC_RST      3'h0

// Bus answers.
`define TMR_RESP_OKAY    2'b00
`define TMR_RESP_SLVERR  2'b10

`endif

// File: hw/timer_pkg.sv
// Purpose: Types shared by the timer modules.
// Assumes: Nothing beyond the parameter header.
// Notes:   Mode codes above the last legal one stop the counter.
package timer_pkg;

  // Operating modes of the counter.
  typedef enum logic [2:0] {
    MODE_ONESHOT = 3'h0,
    MODE_CONT    = 3'h1,
    MODE_COUNTER = 3'h2,
    MODE_CAPTURE = 3'h3,
    MODE_CAPRST  = 3'h4
  } mode_t;

  // Which events of the capture modes raise the interrupt.
  typedef enum logic [1:0] {
    ISRC_BOTH    = 2'h0,
    ISRC_CAPTURE = 2'h1,
    ISRC_RELOAD  = 2'h2
  } isrc_t;

  typedef logic [2:0] psel_t;

endpackage : timer_pkg

// File: hw/timer_sig_if.sv
// Purpose: Carries prescaler and input-pin signals between timer modules.
// Assumes: All signals on the one system clock.
// Notes:   No clocking block; plain wires.
`timescale 1ns/100ps
interface timer_sig_if;
  import timer_pkg::*;
  logic  run;
  psel_t psel;
  logic  tick;
  logic  rise;
  logic  fall;

  modport presc (input run, input psel, output tick);
  modport edge_det (output rise, output fall);
  modport core (output run, output psel, input tick, input rise,
                input fall);
endinterface : timer_sig_if

// File: hw/timer_prescaler.sv
// Purpose: Divides the system clock into a one-cycle advance enable.
// Assumes: Divide ratio is two to the power of the select field.
// Notes:   Held in reset while the timer is stopped.
`timescale 1ns/100ps
module timer_prescaler
  import timer_pkg::*;
#(
  parameter int PW = 7
)(
  input  wire logic  clk,
  input  wire logic  rst_n,
  timer_sig_if.presc sig
);
  import timer_pkg::*;

  logic [PW-1:0] cnt_reg;
  logic [PW-1:0] lim;
  logic          tick_reg;

  // Terminal count for the selected ratio.
  assign lim = PW'((8'h01 << sig.psel) - 8'h01);
  assign sig.tick = tick_reg;

  // Divider; a stopped timer restarts the division from zero.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else if (!sig.run)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= (cnt_reg == lim);
      cnt_reg  <= (cnt_reg == lim) ? '0 : cnt_reg + 1'b1;
    end
  end

  property p_presc_held;
    @(posedge clk) disable iff (!rst_n)
    !sig.run ##1 !sig.run |-> !sig.tick;
  endproperty
  a_presc_held: assert property (p_presc_held)
    else $error("prescaler ticked while stopped");

endmodule : timer_prescaler

// File: hw/timer_edge.sv
// Purpose: Synchronises the timer input pin and reports clean edges.
// Assumes: The pin is asynchronous to the system clock.
// Notes:   A change counts once the second and third stages agree.
`timescale 1ns/100ps
module timer_edge (
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire logic     pin,
  timer_sig_if.edge_det sig
);
  import timer_pkg::*;

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;
  logic rise_reg;
  logic fall_reg;

  assign sig.rise = rise_reg;
  assign sig.fall = fall_reg;

  // Three-stage synchroniser; only the second stage reads the first.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Filtered level and single-cycle edge pulses.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lvl_reg  <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end
    else
    begin
      rise_reg <= (s2_reg == s3_reg) && s3_reg && !lvl_reg;
      fall_reg <= (s2_reg == s3_reg) && !s3_reg && lvl_reg;
      if (s2_reg == s3_reg)
        lvl_reg <= s3_reg;
    end
  end

endmodule : timer_edge

// File: hw/timer_top.sv
// Purpose: 16-bit up-counting timer with capture, behind an AXI4-Lite slave.
// Assumes: One 200 MHz clock; the input pin obeys the rate limits below.
// Notes:   Function
// Function
// - One-shot reload inverts output one cycle
// - One-shot counts prescaled system clock only
// - Continuous: match interrupts, reloads 0001H, toggles output
// - Written start count affects first pass only
// - Continuous period is reload times prescale
// - Counter mode counts pin edges by polarity
// - Counter mode bypasses the prescaler
// - Counter match interrupts, reloads 0001H, toggles output
// - Interrupt source select filters capture interrupts
// - Reload never writes the capture register
// - Capture restart copies count on pin edge
// - Polarity selects the capturing edge
// - Capture restart interrupts and reloads 0001H
// - Capture sets the capture event flag
// - Without capture, count to reload and restart
`timescale 1ns/100ps
`include "timer_params.svh"
module timer_top (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [3:0]  AWADDR,
  input  wire logic [2:0]  AWPROT,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [3:0]  ARADDR,
  input  wire logic [2:0]  ARPROT,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        TIN,
  output logic             TOUT,
  output logic             TOUT_OE,
  output logic             TIMER_IRQ,
  output timer_pkg::mode_t MODE_NOW
);
  import timer_pkg::*;

  timer_sig_if sig ();

  // Register state.
  logic          en_reg;
  mode_t         mode_reg;
  psel_t         psel_reg;
  logic          pol_reg;
  logic          outen_reg;
  isrc_t         isrc_reg;
  logic          capf_reg;
  logic [15:0]   count_reg;
  logic [15:0]   reload_reg;
  logic [15:0]   capture_reg;
  logic          out_reg;
  logic          irq_reg;

  // Bus state.
  logic          aw_hold_reg;
  logic [3:0]    aw_addr_reg;
  logic          w_hold_reg;
  logic [31:0]   wdata_reg;
  logic [3:0]    wstrb_reg;
  logic          bvalid_reg;
  logic [1:0]    bresp_reg;
  logic          rvalid_reg;
  logic [31:0]   rdata_reg;
  logic [1:0]    rresp_reg;

  // Derived signals.
  logic          do_wr;
  logic          ctrl_wr;
  logic          cnt_wr;
  logic          rld_wr;
  logic          cap_wr;
  logic          wr_hit;
  logic [31:0]   ctrl_word;
  logic [31:0]   ctrl_next;
  logic [31:0]   cnt_next;
  logic [31:0]   rld_next;
  logic [31:0]   cap_next;
  logic          clocked_mode;
  logic          capture_mode;
  logic          edge_sel;
  logic          advance;
  logic          match;
  logic          cap_evt;

  // Byte-lane merge of a write into an existing word.
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[8*i +: 8] = data[8*i +: 8];
    return res;
  endfunction : wmerge

  timer_prescaler #(
    .PW  (7)
  ) u_presc (
    .clk   (CLK),
    .rst_n (RST_N),
    .sig   (sig.presc)
  );

  timer_edge u_edge (
    .clk   (CLK),
    .rst_n (RST_N),
    .pin   (TIN),
    .sig   (sig.edge_det)
  );

  // Control word as software sees it; reserved bits read zero.
  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[`TMR_CTRL_EN] = en_reg;
    ctrl_word[`TMR_CTRL_MODE_HI:`TMR_CTRL_MODE_LO] = mode_reg;
    ctrl_word[`TMR_CTRL_PSC_HI:`TMR_CTRL_PSC_LO] = psel_reg;
    ctrl_word[`TMR_CTRL_POL] = pol_reg;
    ctrl_word[`TMR_CTRL_OUTEN] = outen_reg;
    ctrl_word[`TMR_CTRL_ISRC_HI:`TMR_CTRL_ISRC_LO] = isrc_reg;
    ctrl_word[`TMR_CTRL_CAPF] = capf_reg;
  end

  // A write completes once address and data are both held.
  assign do_wr   = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign ctrl_wr = do_wr && (aw_addr_reg == `TMR_OFF_CTRL);
  assign cnt_wr  = do_wr && (aw_addr_reg == `TMR_OFF_COUNT);
  assign rld_wr  = do_wr && (aw_addr_reg == `TMR_OFF_RELOAD);
  assign cap_wr  = do_wr && (aw_addr_reg == `TMR_OFF_CAPTURE);
  assign wr_hit  = ctrl_wr || cnt_wr || rld_wr || cap_wr;
  assign ctrl_next = wmerge(ctrl_word, wdata_reg, wstrb_reg);
  assign cnt_next  = wmerge({16'h0000, count_reg}, wdata_reg, wstrb_reg);
  assign rld_next  = wmerge({16'h0000, reload_reg}, wdata_reg, wstrb_reg);
  assign cap_next  = wmerge({16'h0000, capture_reg}, wdata_reg, wstrb_reg);

  // Each ready only while its own channel holds nothing and no response waits, so each channel is taken once.
  assign AWREADY = !aw_hold_reg && !bvalid_reg;
  assign WREADY  = !w_hold_reg && !bvalid_reg;
  assign BVALID  = bvalid_reg;
  assign BRESP   = bresp_reg;
  assign ARREADY = !rvalid_reg;
  assign RVALID  = rvalid_reg;
  assign RDATA   = rdata_reg;
  assign RRESP   = rresp_reg;

  // Write channel capture and response.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_hold_reg  <= 1'b0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `TMR_RESP_OKAY;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= AWADDR;
      end
      if (WVALID && WREADY)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= WDATA;
        wstrb_reg  <= WSTRB;
      end
      if (do_wr)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
      end
      else if (bvalid_reg && BREADY)
        bvalid_reg <= 1'b0;
    end
  end

  // Read channel; data come from a register one cycle after the address.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= `TMR_RESP_OKAY;
    end
    else if (ARVALID && ARREADY)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= `TMR_RESP_OKAY;
      unique case (ARADDR)
        `TMR_OFF_CTRL:    rdata_reg <= ctrl_word;
        `TMR_OFF_COUNT:   rdata_reg <= {16'h0000, count_reg};
        `TMR_OFF_RELOAD:  rdata_reg <= {16'h0000, reload_reg};
        `TMR_OFF_CAPTURE: rdata_reg <= {16'h0000, capture_reg};
        default:
        begin
          rdata_reg <= '0;
          rresp_reg <= `TMR_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && RREADY)
      rvalid_reg <= 1'b0;
  end

  // Counting sources: pin edges feed only counter mode; the other
  // modes take prescaled system clocks, so a fast pin never clocks them.
  assign clocked_mode = (mode_reg == MODE_ONESHOT) ||
                        (mode_reg == MODE_CONT) ||
                        (mode_reg == MODE_CAPTURE) ||
                        (mode_reg == MODE_CAPRST);
  assign capture_mode = (mode_reg == MODE_CAPTURE) ||
                        (mode_reg == MODE_CAPRST);
  assign edge_sel = pol_reg ? sig.fall : sig.rise;
  assign sig.run  = en_reg && clocked_mode;
  assign sig.psel = psel_reg;
  assign advance  = en_reg && (clocked_mode ? sig.tick :
                    (mode_reg == MODE_COUNTER) && edge_sel);
  assign match    = advance && (count_reg == reload_reg);
  assign cap_evt  = en_reg && capture_mode && edge_sel;

  // Control register; a one-shot time-out stops the timer unless the
  // same cycle carries a control register write, which then wins.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      en_reg    <= 1'b0;
      mode_reg  <= MODE_ONESHOT;
      psel_reg  <= `TMR_PSC_RST;
      pol_reg   <= 1'b0;
      outen_reg <= 1'b0;
      isrc_reg  <= ISRC_BOTH;
    end
    else if (ctrl_wr)
    begin
      en_reg    <= ctrl_next[`TMR_CTRL_EN];
      mode_reg  <= mode_t'(ctrl_next[`TMR_CTRL_MODE_HI:`TMR_CTRL_MODE_LO]);
      psel_reg  <= ctrl_next[`TMR_CTRL_PSC_HI:`TMR_CTRL_PSC_LO];
      pol_reg   <= ctrl_next[`TMR_CTRL_POL];
      outen_reg <= ctrl_next[`TMR_CTRL_OUTEN];
      isrc_reg  <= isrc_t'(ctrl_next[`TMR_CTRL_ISRC_HI:`TMR_CTRL_ISRC_LO]);
    end
    else if (match && (mode_reg == MODE_ONESHOT))
      en_reg <= 1'b0;
  end

  // Capture flag: written one clears it, but a capture in the same
  // cycle sets it, so no event is lost.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      capf_reg <= 1'b0;
    else if (cap_evt)
      capf_reg <= 1'b1;
    else if (ctrl_wr && wstrb_reg[1] && wdata_reg[`TMR_CTRL_CAPF])
      capf_reg <= 1'b0;
  end

  // Counter; any reload or restart goes to 0001H, so a written start
  // value only shapes the first pass.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      count_reg <= `TMR_COUNT_RST;
    else if (cnt_wr)
      count_reg <= cnt_next[15:0];
    else if (cap_evt && (mode_reg == MODE_CAPRST))
      count_reg <= `TMR_RESTART;
    else if (match)
      count_reg <= `TMR_RESTART;
    else if (advance)
      count_reg <= count_reg + 16'h0001;
  end

  // Reload value.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      reload_reg <= `TMR_RELOAD_RST;
    else if (rld_wr)
      reload_reg <= rld_next[15:0];
  end

  // Capture register is written by captures and software writes only, never by a reload.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      capture_reg <= `TMR_CAPTURE_RST;
    else if (cap_wr)
      capture_reg <= cap_next[15:0];
    else if (cap_evt)
      capture_reg <= count_reg;
  end

  // Interrupt pulse; capture modes filter by the source select.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      irq_reg <= 1'b0;
    else if (capture_mode)
      irq_reg <= (cap_evt && (isrc_reg != ISRC_RELOAD)) ||
                 (match && (isrc_reg != ISRC_CAPTURE));
    else
      irq_reg <= match;
  end

  // Output pin: a stopped timer shows the polarity level; a running one
  // holds its level and inverts it on each reload outside the capture modes. A one-shot stops at
  // its reload, so the inversion lasts one cycle unless software has
  // flipped the polarity meanwhile, which then leaves a lasting change.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      out_reg <= 1'b0;
    else if (!en_reg)
      out_reg <= pol_reg;
    else if (match && !capture_mode)
      out_reg <= !out_reg;
  end

  assign TOUT      = out_reg;
  assign TOUT_OE   = outen_reg;
  assign TIMER_IRQ = irq_reg;
  assign MODE_NOW  = mode_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_oneshot_pulse;
    (match && mode_reg == MODE_ONESHOT && !ctrl_wr && TOUT == pol_reg)
      ##1 !ctrl_wr |-> $changed(TOUT) ##1 $changed(TOUT);
  endproperty
  a_oneshot_pulse: assert property (p_oneshot_pulse)
    else $error("one-shot output pulse not one cycle");

  property p_oneshot_clk;
    (mode_reg == MODE_ONESHOT) && en_reg && !sig.tick && !cnt_wr
      |=> $stable(count_reg);
  endproperty
  a_oneshot_clk: assert property (p_oneshot_clk)
    else $error("one-shot advanced without prescaler tick");

  property p_reload_one;
    match && !cnt_wr |=> count_reg == `TMR_RESTART;
  endproperty
  a_reload_one: assert property (p_reload_one)
    else $error("reload did not restart at 0001H");

  property p_match_irq;
    match && !capture_mode |=> TIMER_IRQ;
  endproperty
  a_match_irq: assert property (p_match_irq)
    else $error("match raised no interrupt");

  property p_counter_step;
    (mode_reg == MODE_COUNTER) && en_reg && edge_sel && !match && !cnt_wr
      |=> count_reg == $past(count_reg) + 16'h0001;
  endproperty
  a_counter_step: assert property (p_counter_step)
    else $error("counter mode edge did not add one");

  property p_counter_nopsc;
    (mode_reg == MODE_COUNTER) && !edge_sel |-> !advance && !sig.run;
  endproperty
  a_counter_nopsc: assert property (p_counter_nopsc)
    else $error("counter mode advanced without an edge");

  property p_isrc;
    capture_mode && isrc_reg == ISRC_CAPTURE && !cap_evt |=> !TIMER_IRQ;
  endproperty
  a_isrc: assert property (p_isrc)
    else $error("reload interrupt passed capture-only filter");

  property p_cap_keep;
    !cap_evt && !cap_wr |=> $stable(capture_reg);
  endproperty
  a_cap_keep: assert property (p_cap_keep)
    else $error("capture register changed without capture");

  property p_capture;
    cap_evt && !cap_wr |=> capture_reg == $past(count_reg) && capf_reg;
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture value or flag wrong");

  property p_oneshot_stop;
    match && mode_reg == MODE_ONESHOT && !ctrl_wr |=> !en_reg ##1 !advance;
  endproperty
  a_oneshot_stop: assert property (p_oneshot_stop)
    else $error("one-shot did not stop at time-out");

  c_cont_reload: cover property (match && mode_reg == MODE_CONT);
  c_caprst: cover property (cap_evt && mode_reg == MODE_CAPRST);
  c_oneshot: cover property (match && mode_reg == MODE_ONESHOT);

endmodule : timer_top

// File: sim/timer_pin_model.sv
// Purpose: Far side of the timer pins: drives the input, watches the output.
// Assumes: Pin changes are made just after a rising clock edge.
// Notes:   Counts output changes only while the output is enabled.
`timescale 1ns/100ps
module timer_pin_model (
  input  wire logic CLK,
  input  wire logic TOUT,
  input  wire logic TOUT_OE,
  output logic      TIN
);
  int   tog;
  logic last;

  initial
  begin
    TIN = 1'b0;
    tog = 0;
    last = 1'b0;
  end

  // Output watcher; a disabled pin says nothing, so it is not counted.
  always @(posedge CLK)
  begin
    if (TOUT_OE === 1'b1 && TOUT !== last)
      tog++;
    last <= TOUT;
  end

  // Each phase is held eight clocks, well above the two-clock minimum,
  // so the edge has passed the synchroniser before the bench looks.
  task level(input logic v);
    @(posedge CLK);
    TIN <= v;
    repeat (7) @(posedge CLK);
  endtask : level

  task pulse(input int n);
    repeat (n)
    begin
      level(1'b1);
      level(1'b0);
    end
  endtask : pulse
endmodule : timer_pin_model

// File: sim/tb_timer_count_capture_modes.sv
// Purpose: Self-checking bench of the timer through its register bus.
// Assumes: The pin model keeps its phases long enough to be seen.
// Notes:   Only steady periods are timed; first passes vary with setup.
`timescale 1ns/100ps
`include "timer_params.svh"
module tb_timer_count_capture_modes;
  import timer_pkg::*;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, tin, tout, oe, irq;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, cap;
  logic [1:0]  bresp, rresp, r, wresp;
  logic [3:0]  wstrb;
  logic [2:0]  prot;
  mode_t       mode_now;
  int          n_mismatch, cmp_count, irq_n, cyc, last_irq, gap, b, t0;
  logic        t_prev, t_now;

  timer_top timer_top_i (.CLK(clk), .RST_N(rst_n), .AWADDR(awaddr),
    .AWPROT(prot), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
    .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARPROT(prot),
    .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .TIN(tin), .TOUT(tout),
    .TOUT_OE(oe), .TIMER_IRQ(irq), .MODE_NOW(mode_now));

  timer_pin_model timer_pin_model_i (.CLK(clk), .TOUT(tout), .TOUT_OE(oe),
    .TIN(tin));

  always #2.5 clk = ~clk;

  // Interrupt watcher keeps the spacing of the last two pulses.
  always @(posedge clk)
  begin
    cyc++;
    if (irq === 1'b1)
    begin
      gap = cyc - last_irq;
      last_irq = cyc;
      irq_n++;
      t_prev = t_now;
      t_now = tout;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Address and data go out together; each is dropped once taken.
  task wr(input logic [3:0] a, input logic [31:0] v);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge clk);
      if (!ad && awready === 1'b1)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1)
      begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    wresp = bresp;
    bready <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    v = rdata;
    e = rresp;
    rready <= 1'b0;
  endtask : rd

  task rc(input logic [3:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(d, e);
  endtask : rc

  function logic [31:0] cw(input logic [2:0] m, input logic [2:0] p,
                           input logic pol, input logic [1:0] s,
                           input logic en);
    return {20'h0, 1'b0, s, 1'b1, pol, p, m, en};
  endfunction : cw

  // Configure while stopped, load the counts, then enable last.
  task go(input logic [2:0] m, input logic [2:0] p, input logic pol,
          input logic [1:0] s, input logic [15:0] rl, input logic [15:0] c);
    wr(`TMR_OFF_CTRL, cw(m, p, pol, s, 1'b0));
    wr(`TMR_OFF_RELOAD, {16'h0, rl});
    wr(`TMR_OFF_COUNT, {16'h0, c});
    wr(`TMR_OFF_CTRL, cw(m, p, pol, s, 1'b1));
  endtask : go

  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_sim;
  end

  initial
  begin
    {clk, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    prot = 3'h0;
    {n_mismatch, cmp_count, irq_n, cyc, last_irq, gap} = '0;
    {t_prev, t_now} = '0;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rc(`TMR_OFF_CTRL, 32'h0);
    rc(`TMR_OFF_COUNT, 32'h1);
    rc(`TMR_OFF_RELOAD, 32'hffff);
    rc(`TMR_OFF_CAPTURE, 32'h0);
    rd(4'h2, d, r);
    chk({30'h0, r}, {30'h0, `TMR_RESP_SLVERR});
    wr(4'h2, 32'h0);
    chk({30'h0, wresp}, {30'h0, `TMR_RESP_SLVERR});
    // Only the low byte lane is enabled, so the upper reload byte stays.
    wstrb <= 4'h1;
    wr(`TMR_OFF_RELOAD, 32'h1234);
    wstrb <= 4'hf;
    rc(`TMR_OFF_RELOAD, 32'hff34);
    $display("test reset values done");
    // Steady period must be the reload of 4 times the prescale power of two.
    for (int p = 0; p < 3; p++)
    begin
      go(MODE_CONT, p[2:0], 1'b0, ISRC_BOTH, 16'h4, 16'h3);
      while (irq_n < 3 * (p + 1)) @(posedge clk);
      chk(gap, 4 << p);
      chk(t_now ^ t_prev, 1);
    end
    $display("test continuous done");
    wr(`TMR_OFF_CTRL, cw(MODE_ONESHOT, 3'h1, 1'b0, ISRC_BOTH, 1'b0));
    wr(`TMR_OFF_RELOAD, 32'h6);
    wr(`TMR_OFF_COUNT, 32'h1);
    b = irq_n;
    t0 = timer_pin_model_i.tog;
    wr(`TMR_OFF_CTRL, cw(MODE_ONESHOT, 3'h1, 1'b0, ISRC_BOTH, 1'b1));
    timer_pin_model_i.pulse(3);
    chk(irq_n - b, 1);
    chk(timer_pin_model_i.tog - t0, 2);
    rc(`TMR_OFF_CTRL, cw(MODE_ONESHOT, 3'h1, 1'b0, ISRC_BOTH, 1'b0));
    rc(`TMR_OFF_COUNT, 32'h1);
    // Polarity flipped after the start turns the pulse into a level.
    go(MODE_ONESHOT, 3'h1, 1'b0, ISRC_BOTH, 16'h20, 16'h1);
    wr(`TMR_OFF_CTRL, cw(MODE_ONESHOT, 3'h1, 1'b1, ISRC_BOTH, 1'b1));
    b = irq_n;
    t0 = timer_pin_model_i.tog;
    while (irq_n == b) @(posedge clk);
    repeat (4) @(posedge clk);
    chk(timer_pin_model_i.tog - t0, 1);
    chk(tout, 1);
    $display("test one-shot done");
    // A large prescale would stall the count if it were not bypassed.
    go(MODE_COUNTER, 3'h3, 1'b0, ISRC_BOTH, 16'h3, 16'h1);
    timer_pin_model_i.pulse(2);
    rc(`TMR_OFF_COUNT, 32'h3);
    b = irq_n;
    timer_pin_model_i.pulse(1);
    chk(irq_n - b, 1);
    rc(`TMR_OFF_COUNT, 32'h1);
    go(MODE_COUNTER, 3'h0, 1'b1, ISRC_BOTH, 16'h3, 16'h1);
    timer_pin_model_i.level(1'b1);
    rc(`TMR_OFF_COUNT, 32'h1);
    timer_pin_model_i.level(1'b0);
    rc(`TMR_OFF_COUNT, 32'h2);
    $display("test counter done");
    go(MODE_CAPRST, 3'h0, 1'b0, ISRC_BOTH, 16'hffff, 16'h1);
    repeat (60) @(posedge clk);
    b = irq_n;
    timer_pin_model_i.pulse(1);
    chk(irq_n - b, 1);
    rd(`TMR_OFF_CTRL, d, r);
    chk(d[11], 1);
    rd(`TMR_OFF_CAPTURE, cap, r);
    chk(cap > 40, 1);
    rd(`TMR_OFF_COUNT, d, r);
    chk(d < 32, 1);
    go(MODE_CAPRST, 3'h0, 1'b1, ISRC_BOTH, 16'hffff, 16'h1);
    b = irq_n;
    timer_pin_model_i.level(1'b1);
    chk(irq_n - b, 0);
    timer_pin_model_i.level(1'b0);
    chk(irq_n - b, 1);
    wr(`TMR_OFF_CTRL, cw(MODE_CAPRST, 3'h0, 1'b1, ISRC_BOTH, 1'b1) | 32'h800);
    rc(`TMR_OFF_CTRL, cw(MODE_CAPRST, 3'h0, 1'b1, ISRC_BOTH, 1'b1));
    $display("test capture restart done");
    wr(`TMR_OFF_CAPTURE, 32'h0);
    go(MODE_CAPTURE, 3'h0, 1'b0, ISRC_RELOAD, 16'h5, 16'h1);
    b = irq_n;
    while (irq_n < b + 2) @(posedge clk);
    chk(gap, 5);
    chk(mode_now, MODE_CAPTURE);
    rc(`TMR_OFF_CAPTURE, 32'h0);
    wr(`TMR_OFF_CTRL, cw(MODE_CAPTURE, 3'h0, 1'b0, ISRC_CAPTURE, 1'b1));
    b = irq_n;
    repeat (30) @(posedge clk);
    chk(irq_n - b, 0);
    timer_pin_model_i.pulse(1);
    chk(irq_n - b, 1);
    $display("test capture done");
    end_sim;
  end
endmodule : tb_timer_count_capture_modes
